// >>> sac_core.sv
// Conversion sequencer and serial result shifter of an 18-bit SAR converter
`timescale 1ns/1ps

module sac_core #(
    parameter int RESULT_BITS = sac_pkg::RESULT_W,
    parameter int CONV_CYCLES = sac_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic conversion_start_i,
    input wire logic shift_clk_i,
    input wire logic read_enable_or_chain_in_i,
    input wire logic chain_mode_i,
    input wire logic [RESULT_BITS-1:0] conv_value_i,
    output logic busy_o,
    output logic powered_up_o,
    output logic acquiring_o,
    output logic serial_result_out_o,
    output logic serial_result_out_oe_o,
    output logic [RESULT_BITS-1:0] result_o
);
    import sac_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    initial begin
        if (RESULT_BITS != RESULT_W) begin
            $error("sac_core: RESULT_BITS must match the package width");
        end
        if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << CNT_W)) begin
            $error("sac_core: CONV_CYCLES out of counter range");
        end
    end

    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] pins_raw;
    logic [3:0] pins_sync;
    logic start_lvl;
    logic sck_lvl;
    logic rdsdi_lvl;
    logic chain_lvl;

    assign pins_raw = {chain_mode_i, read_enable_or_chain_in_i, shift_clk_i,
                       conversion_start_i};

    sac_sync3 #(
        .WIDTH(4)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pins_raw),
        .level_o(pins_sync)
    );

    assign start_lvl = pins_sync[0];
    assign sck_lvl = pins_sync[1];
    assign rdsdi_lvl = pins_sync[2];
    assign chain_lvl = pins_sync[3];

    // ************************************************************
    // Registers
    // ************************************************************
    sac_state_t state_r;
    sac_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic start_prev_r;
    logic sck_prev_r;
    logic rdsdi_prev_r;
    logic [RESULT_BITS-1:0] result_r;
    logic [RESULT_BITS-1:0] result_nxt;
    logic [RESULT_BITS-1:0] shreg_r;
    logic [RESULT_BITS-1:0] shreg_nxt;

    // ************************************************************
    // Edge detection on filtered pins
    // ************************************************************
    logic start_rise;
    logic sck_rise;
    logic rden_fall;
    logic chain_mode;

    assign start_rise = start_lvl & ~start_prev_r;
    assign sck_rise = sck_lvl & ~sck_prev_r;
    assign rden_fall = ~rdsdi_lvl & rdsdi_prev_r;
    assign chain_mode = (chain_lvl != CHAIN_SEL_NORMAL);

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    logic conv_done;
    logic conv_begin;

    // One decode of the converting state, shared by busy, power and done
    function automatic logic is_converting(input sac_state_t st);
        return (st == SAC_ST_CONVERT);
    endfunction

    // A start edge only counts while asleep; mid-conversion edges are dropped
    assign conv_begin = (state_r == SAC_ST_ASLEEP) && start_rise;
    // Fixed internal count, rounded down so 527 ns is never exceeded
    assign conv_done = is_converting(state_r) && (cnt_r == CONV_LAST);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            SAC_ST_ASLEEP: begin
                if (conv_begin) begin
                    state_nxt = SAC_ST_CONVERT;
                    cnt_nxt = CNT_ONE;
                end
            end
            SAC_ST_CONVERT: begin
                if (conv_done) begin
                    state_nxt = SAC_ST_ASLEEP;
                    cnt_nxt = CNT_ZERO;
                end else begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            default: begin
                state_nxt = SAC_ST_ASLEEP;
                cnt_nxt = CNT_ZERO;
            end
        endcase
    end

    // Latest result held across power-down for readout
    assign result_nxt = conv_done ? conv_value_i : result_r;

    // ************************************************************
    // Output shifter
    // ************************************************************
    logic out_enabled;
    logic shift_in_bit;

    // Normal mode: read-enable low drives; chain mode: always driven
    assign out_enabled = chain_mode | (rdsdi_lvl == READ_EN_ACTIVE);
    // Chain input feeds the tail so upstream data follows after 18 shifts
    assign shift_in_bit = chain_mode ? rdsdi_lvl : 1'b0;

    // Load beats shift: a fresh result must present its MSB first
    always_comb begin
        shreg_nxt = shreg_r;
        if (conv_done) begin
            shreg_nxt = conv_value_i;
        end else if (!chain_mode && rden_fall) begin
            shreg_nxt = result_r;
        end else if (sck_rise && out_enabled) begin
            shreg_nxt = {shreg_r[RESULT_BITS-2:0], shift_in_bit};
        end
    end

    // ************************************************************
    // State flops
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_r <= SAC_ST_ASLEEP;
            cnt_r <= CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Edge history; reset to low so a high pin at release looks like an edge
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            start_prev_r <= 1'b0;
            sck_prev_r <= 1'b0;
            rdsdi_prev_r <= 1'b0;
        end else begin
            start_prev_r <= start_lvl;
            sck_prev_r <= sck_lvl;
            rdsdi_prev_r <= rdsdi_lvl;
        end
    end

    // Result and shifter data
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            result_r <= RESULT_RST;
            shreg_r <= RESULT_RST;
        end else begin
            result_r <= result_nxt;
            shreg_r <= shreg_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Busy is the conversion state itself, so it cannot glitch
    assign busy_o = is_converting(state_r);
    // Powered only while converting; sleeps through acquisition and readout
    assign powered_up_o = is_converting(state_r);
    assign acquiring_o = (state_r == SAC_ST_ASLEEP);
    // MSB sits at the top until the first rising shift edge moves it
    assign serial_result_out_o = shreg_r[RESULT_BITS-1];
    assign serial_result_out_oe_o = out_enabled;
    assign result_o = result_r;

endmodule

// >>> sac_pkg.sv
// Shared constants for the converter sequencing and serial readout block
package sac_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RESULT_W = 18;
    localparam int CNT_W = 4;

    // ************************************************************
    // Timing figures and derived cycle counts
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    // Longest conversion, rounded down so we never exceed it
    localparam int CONV_TIME_NS = 527;
    localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    // Host-side figures, kept for reference; neither the bench nor the host reads them
    localparam int START_GUARD_NS = 40;
    localparam int ACQ_TIME_NS = 460;

    // ************************************************************
    // Reset values and pin levels
    // ************************************************************
    localparam logic [RESULT_W-1:0] RESULT_RST = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic CHAIN_SEL_NORMAL = 1'b0;
    localparam logic READ_EN_ACTIVE = 1'b0;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [0:0] {
        SAC_ST_ASLEEP,
        SAC_ST_CONVERT
    } sac_state_t;

endpackage

// >>> sac_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module sac_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    import sac_pkg::*;

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("sac_sync3: WIDTH must be at least 1");
        end
    end

    // ************************************************************
    // Agreement of stages two and three accepts a change
    // ************************************************************
    // First stage is read only by the second one (metastability)
    assign level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    assign level_o = level_r;

    // Shift chain, all clear on reset
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

endmodule

// >>> sac_monitor.sv
// Checker for the conversion sequencer and serial readout ports
`timescale 1ns/1ps

module sac_monitor #(
    parameter int RESULT_BITS = sac_pkg::RESULT_W,
    parameter int CONV_CYCLES = sac_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic conversion_start_i,
    input wire logic shift_clk_i,
    input wire logic read_enable_or_chain_in_i,
    input wire logic chain_mode_i,
    input wire logic [RESULT_BITS-1:0] conv_value_i,
    input wire logic busy_o,
    input wire logic powered_up_o,
    input wire logic acquiring_o,
    input wire logic serial_result_out_o,
    input wire logic serial_result_out_oe_o,
    input wire logic [RESULT_BITS-1:0] result_o
);
    import sac_pkg::*;
    // ********************
    // Port relations
    // ********************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Busy length is fixed, so a restart shows as a longer pulse
    property p_busy_len; $rose(busy_o) |-> busy_o [*5] ##1 !busy_o; endproperty
    property p_start; $rose(conversion_start_i) && !busy_o |-> ##[3:6] busy_o; endproperty
    property p_power; powered_up_o == busy_o && acquiring_o == !busy_o; endproperty
    property p_load;
        $fell(busy_o) |-> result_o == $past(conv_value_i)
            && serial_result_out_o == result_o[RESULT_BITS-1];
    endproperty
    property p_keep; !busy_o && !$past(busy_o) |-> $stable(result_o); endproperty
    property p_hiz;
        (!chain_mode_i && read_enable_or_chain_in_i) [*6] |-> !serial_result_out_oe_o;
    endproperty
    property p_drive;
        (!chain_mode_i && !read_enable_or_chain_in_i) [*6] |-> serial_result_out_oe_o;
    endproperty
    property p_chain_oe; chain_mode_i [*6] |-> serial_result_out_oe_o; endproperty
    // Eight quiet samples leave room for the pin synchronisers
    property p_idle;
        (!busy_o && !shift_clk_i && $stable(read_enable_or_chain_in_i)) [*8]
            |=> $stable(serial_result_out_o);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_start: assert property (p_start) else $error("start not taken");
    a_power: assert property (p_power) else $error("power state wrong");
    a_load: assert property (p_load) else $error("result not loaded");
    a_keep: assert property (p_keep) else $error("result lost");
    a_hiz: assert property (p_hiz) else $error("output not released");
    a_drive: assert property (p_drive) else $error("output not driven");
    a_chain_oe: assert property (p_chain_oe) else $error("chain output off");
    a_idle: assert property (p_idle) else $error("output moved unclocked");
    c_conv: cover property ($rose(busy_o));
    c_chain: cover property (chain_mode_i && $rose(shift_clk_i));
    c_hiz: cover property ($fell(serial_result_out_oe_o));
endmodule

bind sac_core sac_monitor #(.RESULT_BITS(RESULT_BITS), .CONV_CYCLES(CONV_CYCLES)) u_mon (
    .clk_i(clk_i), .resetn_i(resetn_i), .conversion_start_i(conversion_start_i),
    .shift_clk_i(shift_clk_i), .read_enable_or_chain_in_i(read_enable_or_chain_in_i),
    .chain_mode_i(chain_mode_i), .conv_value_i(conv_value_i), .busy_o(busy_o),
    .powered_up_o(powered_up_o), .acquiring_o(acquiring_o),
    .serial_result_out_o(serial_result_out_o),
    .serial_result_out_oe_o(serial_result_out_oe_o), .result_o(result_o));

// >>> sac_host.sv
// Host model: conversion start, shift clock and read enable
`timescale 1ns/1ps

module sac_host (
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic sdo_i,
    input wire logic oe_i,
    output logic start_o,
    output logic sck_o,
    output logic rden_o
);
    logic line;
    logic last_r = 1'b0;
    // ********************
    // Line and drivers
    // ********************
    // A released line shows the inverse of its last level
    assign line = oe_i ? sdo_i : ~last_r;
    always @(posedge clk_i) last_r <= line;
    initial begin
        start_o = 1'b0;
        sck_o = 1'b0;
        rden_o = 1'b1;
    end
    task automatic set_rden(input logic v);
        @(negedge clk_i) rden_o = v;
    endtask
    // Start held high until busy falls; glitch makes a refused edge
    task automatic convert(input bit glitch, output int n);
        int k;
        k = 0;
        n = 0;
        @(negedge clk_i) start_o = 1'b1;
        if (glitch) begin
            repeat (2) @(negedge clk_i);
            start_o = 1'b0;
            repeat (2) @(negedge clk_i);
            start_o = 1'b1;
        end
        while (!busy_i && k < 20) begin
            @(negedge clk_i);
            k++;
        end
        while (busy_i && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        start_o = 1'b0;
        repeat (5) @(negedge clk_i);
    endtask
    // Bit taken just before each rise; clock rests low outside frames
    task automatic shift(input int n, input bit chain, input logic [35:0] din,
                         output logic [35:0] dout);
        dout = '0;
        @(negedge clk_i);
        if (chain) rden_o = din[35];
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            dout = {dout[34:0], line};
            sck_o = 1'b1;
            repeat (4) @(negedge clk_i);
            sck_o = 1'b0;
            if (chain && i < n - 1) rden_o = din[34-i];
            repeat (3) @(negedge clk_i);
        end
    endtask
endmodule

// >>> sar_adc_conversion_serial_readout_bench.sv
// Self-checking bench for the conversion sequencer and serial readout
`timescale 1ns/1ps

module sar_adc_conversion_serial_readout_bench;
    import sac_pkg::*;
    localparam logic [17:0] VAL_A = 18'h2A5C3;
    localparam logic [17:0] VAL_B = 18'h15A3C;
    localparam logic [17:0] VAL_C = 18'h3F00F;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic chain_mode_i = 1'b0;
    logic [RESULT_W-1:0] conv_value_i = 18'h00000;
    logic start, sck, rden, busy, pwr, acq, serial_result_out, oe;
    logic [RESULT_W-1:0] res;
    logic [35:0] dout;
    int err_count = 0;
    int checked = 0;
    int n;
    // ********************
    // Instances and clock
    // ********************
    sac_core DUT (.clk_i(clk_i), .resetn_i(resetn_i), .conversion_start_i(start),
        .shift_clk_i(sck), .read_enable_or_chain_in_i(rden), .chain_mode_i(chain_mode_i),
        .conv_value_i(conv_value_i), .busy_o(busy), .powered_up_o(pwr), .acquiring_o(acq),
        .serial_result_out_o(serial_result_out), .serial_result_out_oe_o(oe), .result_o(res));
    sac_host HOST (.clk_i(clk_i), .busy_i(busy), .sdo_i(serial_result_out), .oe_i(oe), .start_o(start),
        .sck_o(sck), .rden_o(rden));
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Extra start edge mid-conversion must not stretch busy
    task automatic t_normal();
        @(negedge clk_i) conv_value_i = VAL_A;
        HOST.set_rden(1'b0);
        HOST.convert(1'b1, n);
        chk("busy cycles", 36'(CONV_CYCLES), 36'(n));
        chk("result", 36'(VAL_A), 36'(res));
        chk("acquiring", 36'h1, 36'(acq));
        HOST.shift(4, 1'b0, 36'h0, dout);
        chk("first bits", 36'(VAL_A[17:14]), dout);
        $display("normal test done");
    endtask
    // Release after the partial read, clocks while released, then restart of readout from the MSB
    task automatic t_reread();
        HOST.set_rden(1'b1);
        repeat (6) @(negedge clk_i);
        chk("oe released", 36'h0, 36'(oe));
        HOST.shift(3, 1'b0, 36'h0, dout);
        HOST.set_rden(1'b0);
        repeat (10) @(negedge clk_i);
        chk("oe driven", 36'h1, 36'(oe));
        HOST.shift(18, 1'b0, 36'h0, dout);
        chk("reread bits", 36'(VAL_A), dout);
        $display("reread test done");
    endtask
    // Local result first, then the upstream word 18 clocks later
    task automatic t_chain();
        @(negedge clk_i) chain_mode_i = 1'b1;
        conv_value_i = VAL_B;
        HOST.set_rden(1'b1);
        repeat (6) @(negedge clk_i);
        chk("chain oe", 36'h1, 36'(oe));
        HOST.convert(1'b0, n);
        HOST.shift(36, 1'b1, {VAL_C, 18'h0}, dout);
        chk("chain bits", {VAL_B, VAL_C}, dout);
        $display("chain test done");
    endtask
    initial begin
        repeat (3) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (5) @(negedge clk_i);
        chk("idle busy", 36'h0, 36'(busy));
        t_normal();
        t_reread();
        t_chain();
        tally_and_finish();
    end
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end
endmodule
